// File: rtl/scs_pkg.sv
// package of constants and types for the switchgear command supervisor
package scs_pkg;
  localparam logic [1:0] POS_INDET = 2'h0;
  localparam logic [1:0] POS_OPEN = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_DISTURB = 2'h3;
  localparam logic [1:0] AUTH_NONE = 2'h0;
  localparam logic [1:0] AUTH_LOCAL = 2'h1;
  localparam logic [1:0] AUTH_REMOTE = 2'h2;
  localparam logic [1:0] AUTH_BOTH = 2'h3;
  localparam logic [1:0] BYP_OFF = 2'h0;
  localparam logic [1:0] BYP_SINGLE = 2'h1;
  localparam logic [1:0] BYP_PERM = 2'h2;
  localparam logic [1:0] BYP_TIMED = 2'h3;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;
  localparam int ILK_N = 3;
  localparam int SLOT_N = 8;
  localparam int CMD_PULSE_CYC = 4;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MANPOS = 8'h04;
  localparam logic [7:0] ADDR_TRAVEL = 8'h08;
  localparam logic [7:0] ADDR_DWELL = 8'h0C;
  localparam logic [7:0] ADDR_HOLD = 8'h10;
  localparam logic [7:0] ADDR_BYPASS = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1C;
  // control register bit fields
  localparam int CTRL_AUTH_LSB = 0;
  localparam int CTRL_BYP_LSB = 2;
  localparam int CTRL_LATCH_BIT = 4;
  localparam int CTRL_OPENWIRED_BIT = 5;
  localparam int CTRL_SLOT_LSB = 8;
  // command register bits (self-clearing)
  localparam int CMD_PANEL_CLOSE = 0;
  localparam int CMD_PANEL_OPEN = 1;
  localparam int CMD_REM_CLOSE = 2;
  localparam int CMD_REM_OPEN = 3;
  localparam int CMD_ACK = 4;
  localparam int CMD_BYP_ARM = 5;
  localparam int CMD_CLR_RESULT = 6;
  localparam logic [31:0] CTRL_RESET = 32'h00000023;
  typedef enum logic [2:0] {ST_IDLE, ST_PULSE, ST_TRAVEL, ST_DWELL} scs_op_t;
endpackage

// File: rtl/scs_supervisor.sv
// switchgear command supervisor: position check, interlocks, trip manager, commands
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - open command with open contact only starts travel timer, shows intermediate
// - open feedback before timeout sets open, success; clears intermediate together
// - travel timeout without feedback: unsuccessful, disturbed, intermediate cleared
// - after close travel time, optional dwell timer shows intermediate, then closed
// - position codes: 0 intermediate, 1 open, 2 closed
// - no open contact assigned: position code held at 3, disturbed
// - three interlocks per direction, any active blocks that direction
// - protection open and auto-reclose close bypass interlocks; separate trip block
// - assigned trip sources ORed into one switchgear trip command
// - only trip manager output drives switchgear; unassigned trips ignored
// - trip held a minimum time; latched or non-latched configurable
// - latch released after sources drop and acknowledge, unlatch or no assignment
// - one external close and one external open request input
// - open wins; close on rising edge, open while level asserted
// - remote commands only with authority remote or local-and-remote
// - authority none/local/remote/both gates switching, never protection trips or auto-reclose
// - bypass modes single, permanent, timed; duration also limits single mode
// - bypass also enabled by the assigned bypass input signal
// - manual position override with overridden flag
// - one command at a time; new commands ignored while one runs
// - command suppressed when switchgear already in requested position
// - held panel close gives exactly one close pulse
module scs_supervisor
  import scs_pkg::*;
#(
  parameter int SLOTS = SLOT_N
) (
  input wire logic clock, // 25 MHz
  input wire logic rst, // async, active high
  input wire logic [7:0] addr, // register address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic aux_open_in, // open auxiliary contact pin
  input wire logic [ILK_N-1:0] ilk_close, // close interlocks
  input wire logic [ILK_N-1:0] ilk_open, // open interlocks
  input wire logic [SLOTS-1:0] prot_trip, // protection trip sources
  input wire logic trip_block, // blocks protection trip
  input wire logic trip_release_signal, // assigned trip acknowledge
  input wire logic auto_reclose_unit, // reclose request
  input wire logic external_close_request, // external close
  input wire logic external_open_request, // external open
  input wire logic bypass_duration, // bypass enable signal
  output logic trip_cmd, // trip coil drive
  output logic close_cmd, // close coil drive
  output logic open_cmd, // open coil drive (control)
  output logic [1:0] position, // validated position code
  output logic pos_open, // open flag
  output logic pos_closed, // closed flag
  output logic pos_indet, // intermediate flag
  output logic pos_disturb, // disturbed flag
  output logic command_success_flag, // last op succeeded
  output logic command_fail_flag, // last op failed
  output logic pos_overridden, // manual override active
  output logic bypass_active // interlock bypass on
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0] manpos;
    logic [TMR_W-1:0] travel_pre;
    logic [TMR_W-1:0] dwell_pre;
    logic [TMR_W-1:0] hold_pre;
    logic [TMR_W-1:0] byp_pre;
    logic [TMR_W-1:0] op_tmr;
    logic [TMR_W-1:0] hold_tmr;
    logic [TMR_W-1:0] byp_tmr;
    scs_op_t op;
    logic op_open;
    logic [2:0] pulse_cnt;
    logic [1:0] aux_sync;
    logic [1:0] ext_close_sync;
    logic [1:0] ext_open_sync;
    logic ext_close_prev;
    logic ar_prev;
    logic byp_sig_prev;
    logic panel_close_seen;
    logic trip_latched;
    logic ack_pend;
    logic byp_on;
    logic [1:0] pos_v;
    logic succ;
    logic fail;
    logic trip;
    logic close_o;
    logic open_o;
    logic [31:0] rdata;
  } scs_state_t;

  scs_state_t s_reg, s_next;

  // timer preset reload helper, never below one tick
  function automatic logic [TMR_W-1:0] tmr_load(input logic [TMR_W-1:0] pre);
    tmr_load = (pre == TMR_ZERO) ? TMR_ONE : pre;
  endfunction

  // current validated position incl. override
  function automatic logic [1:0] eff_pos(input scs_state_t st);
    eff_pos = st.manpos[2] ? st.manpos[1:0] : st.pos_v;
  endfunction

  logic [1:0] auth;
  logic [1:0] byp_mode;
  logic latch_en;
  logic open_wired;
  logic [SLOTS-1:0] slot_en;
  logic aux_q;
  logic any_trip;
  logic bypass;
  logic remote_ok;
  logic local_ok;
  logic req_close;
  logic req_open;
  logic req_ar;
  logic cmd_wr;
  logic [1:0] cur_pos;

  // decoded configuration
  always_comb begin
    auth = s_reg.ctrl[CTRL_AUTH_LSB +: 2];
    byp_mode = s_reg.ctrl[CTRL_BYP_LSB +: 2];
    latch_en = s_reg.ctrl[CTRL_LATCH_BIT];
    open_wired = s_reg.ctrl[CTRL_OPENWIRED_BIT];
    slot_en = s_reg.ctrl[CTRL_SLOT_LSB +: SLOTS];
    aux_q = s_reg.aux_sync[1];
    cur_pos = eff_pos(s_reg);
    bypass = s_reg.byp_on;
    cmd_wr = wr && (addr == ADDR_CMD);
  end

  always_comb begin
    s_next = s_reg;
    // open contact and external request pins pass two flops before any logic reads them
    // pin synchronisers
    s_next.aux_sync = {s_reg.aux_sync[0], aux_open_in};
    s_next.ext_close_sync = {s_reg.ext_close_sync[0], external_close_request};
    s_next.ext_open_sync = {s_reg.ext_open_sync[0], external_open_request};
    s_next.ext_close_prev = s_reg.ext_close_sync[1];
    s_next.ar_prev = auto_reclose_unit;
    s_next.byp_sig_prev = bypass_duration;
    s_next.ack_pend = s_reg.ack_pend;
    // register writes
    if (wr) begin
      case (addr)
        ADDR_CTRL: s_next.ctrl = wdata;
        ADDR_MANPOS: s_next.manpos = wdata[2:0];
        ADDR_TRAVEL: s_next.travel_pre = wdata[TMR_W-1:0];
        ADDR_DWELL: s_next.dwell_pre = wdata[TMR_W-1:0];
        ADDR_HOLD: s_next.hold_pre = wdata[TMR_W-1:0];
        ADDR_BYPASS: s_next.byp_pre = wdata[TMR_W-1:0];
        default: ;
      endcase
    end
    if (cmd_wr && wdata[CMD_CLR_RESULT]) begin
      s_next.succ = 1'b0;
      s_next.fail = 1'b0;
    end
    remote_ok = (auth == AUTH_REMOTE) || (auth == AUTH_BOTH);
    local_ok = (auth == AUTH_LOCAL) || (auth == AUTH_BOTH);
    req_close = 1'b0;
    if (cmd_wr && wdata[CMD_PANEL_CLOSE] && local_ok && !s_reg.panel_close_seen)
      req_close = 1'b1;
    s_next.panel_close_seen = cmd_wr ? wdata[CMD_PANEL_CLOSE] : s_reg.panel_close_seen;
    if (cmd_wr && wdata[CMD_REM_CLOSE] && remote_ok)
      req_close = 1'b1;
    if (s_reg.ext_close_sync[1] && !s_reg.ext_close_prev && remote_ok)
      req_close = 1'b1;
    req_open = (cmd_wr && wdata[CMD_PANEL_OPEN] && local_ok) ||
               (cmd_wr && wdata[CMD_REM_OPEN] && remote_ok) ||
               (s_reg.ext_open_sync[1] && remote_ok); // level acting
    req_ar = auto_reclose_unit && !s_reg.ar_prev;
    if (!bypass) begin
      if (|ilk_open)
        req_open = 1'b0;
      if (|ilk_close)
        req_close = 1'b0;
    end
    if (req_open) begin
      req_close = 1'b0;
      req_ar = 1'b0;
    end
    if (cur_pos == POS_OPEN)
      req_open = 1'b0;
    if (cur_pos == POS_CLOSED) begin
      req_close = 1'b0;
      req_ar = 1'b0;
    end
    // a forgotten bypass is dangerous, so only permanent mode never runs out
    // bypass arming and timing
    if ((cmd_wr && wdata[CMD_BYP_ARM] && byp_mode != BYP_OFF) ||
        (bypass_duration && !s_reg.byp_sig_prev)) begin
      s_next.byp_on = 1'b1;
      s_next.byp_tmr = tmr_load(s_reg.byp_pre);
    end else if (s_reg.byp_on && byp_mode != BYP_PERM) begin
      if (s_reg.byp_tmr <= TMR_ONE)
        s_next.byp_on = 1'b0;
      else
        s_next.byp_tmr = s_reg.byp_tmr - TMR_ONE;
    end
    if (byp_mode == BYP_OFF && !bypass_duration)
      s_next.byp_on = s_next.byp_on && (s_reg.byp_tmr > TMR_ONE);
    // operation sequencer
    s_next.close_o = 1'b0;
    s_next.open_o = 1'b0;
    case (s_reg.op)
      ST_IDLE: begin
        if (req_open || req_close || req_ar) begin
          s_next.op = ST_PULSE;
          s_next.op_open = req_open;
          // idle cycle already drives the coil, so load one short
          s_next.pulse_cnt = 3'(CMD_PULSE_CYC - 1);
          s_next.op_tmr = tmr_load(s_reg.travel_pre);
          s_next.succ = 1'b0;
          s_next.fail = 1'b0;
          if (req_open)
            s_next.open_o = 1'b1;
          else
            s_next.close_o = 1'b1;
          // single mode consumed by a command
          if (byp_mode == BYP_SINGLE && s_reg.byp_on && !bypass_duration)
            s_next.byp_on = 1'b0;
          if (open_wired && req_open)
            s_next.pos_v = POS_INDET;
        end
      end
      ST_PULSE, ST_TRAVEL: begin
        if (s_reg.op == ST_PULSE) begin
          s_next.open_o = s_reg.op_open;
          s_next.close_o = !s_reg.op_open;
          if (s_reg.pulse_cnt <= 3'h1)
            s_next.op = ST_TRAVEL;
          else
            s_next.pulse_cnt = s_reg.pulse_cnt - 3'h1;
        end
        if (s_reg.op_open && open_wired && aux_q) begin
          s_next.pos_v = POS_OPEN;
          s_next.succ = 1'b1;
          s_next.op = ST_IDLE;
          s_next.open_o = 1'b0;
        end else if (s_reg.op_tmr <= TMR_ONE) begin
          s_next.open_o = 1'b0;
          s_next.close_o = 1'b0;
          if (s_reg.op_open && open_wired) begin
            s_next.fail = 1'b1;
            s_next.pos_v = POS_DISTURB;
            s_next.op = ST_IDLE;
          end else if (s_reg.dwell_pre != TMR_ZERO) begin
            s_next.op = ST_DWELL;
            s_next.op_tmr = s_reg.dwell_pre;
            s_next.pos_v = POS_INDET;
          end else begin
            s_next.op = ST_IDLE;
            s_next.pos_v = s_reg.op_open ? POS_OPEN : POS_CLOSED;
          end
        end else begin
          s_next.op_tmr = s_reg.op_tmr - TMR_ONE;
        end
      end
      ST_DWELL: begin
        if (s_reg.op_tmr <= TMR_ONE) begin
          s_next.op = ST_IDLE;
          s_next.pos_v = s_reg.op_open ? POS_OPEN : POS_CLOSED;
        end else begin
          s_next.op_tmr = s_reg.op_tmr - TMR_ONE;
        end
      end
      default: s_next.op = ST_IDLE;
    endcase
    // outside an operation the single contact is read directly, but disturbed holds until it shows open
    // idle level follows open contact
    if (open_wired && s_reg.op == ST_IDLE && s_next.op == ST_IDLE &&
        s_reg.pos_v != POS_DISTURB)
      s_next.pos_v = aux_q ? POS_OPEN : POS_CLOSED;
    if (open_wired && s_reg.pos_v == POS_DISTURB && aux_q && s_reg.op == ST_IDLE)
      s_next.pos_v = POS_OPEN;
    // without a wired contact the position cannot be trusted
    // no contact assigned: disturbed
    if (!open_wired)
      s_next.pos_v = POS_DISTURB;
    any_trip = |(prot_trip & slot_en) && !trip_block;
    if (cmd_wr && wdata[CMD_ACK])
      s_next.ack_pend = 1'b1;
    if (trip_release_signal)
      s_next.ack_pend = 1'b1;
    // an acknowledge while a source is still active is dropped
    if (any_trip) begin
      s_next.trip = 1'b1;
      s_next.hold_tmr = tmr_load(s_reg.hold_pre);
      s_next.trip_latched = latch_en;
      s_next.ack_pend = 1'b0;
    end else if (s_reg.trip) begin
      if (s_reg.hold_tmr > TMR_ONE)
        s_next.hold_tmr = s_reg.hold_tmr - TMR_ONE;
      else if (!s_reg.trip_latched || s_reg.ack_pend || !latch_en || slot_en == '0) begin
        s_next.trip = 1'b0;
        s_next.trip_latched = 1'b0;
        s_next.ack_pend = 1'b0;
        s_next.hold_tmr = TMR_ZERO;
      end
    end else begin
      s_next.ack_pend = 1'b0;
    end
    // protection trip ignores interlocks/authority
    // read port, status word
    s_next.rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        ADDR_CTRL: s_next.rdata = s_reg.ctrl;
        ADDR_MANPOS: s_next.rdata = {29'h0, s_reg.manpos};
        ADDR_TRAVEL: s_next.rdata = {8'h00, s_reg.travel_pre};
        ADDR_DWELL: s_next.rdata = {8'h00, s_reg.dwell_pre};
        ADDR_HOLD: s_next.rdata = {8'h00, s_reg.hold_pre};
        ADDR_BYPASS: s_next.rdata = {8'h00, s_reg.byp_pre};
        // status: position, sequencer state, result, trip, bypass, override
        ADDR_STATUS: s_next.rdata = {22'h0, s_reg.manpos[2], s_reg.byp_on,
          s_reg.trip, s_reg.fail, s_reg.succ, 3'(s_reg.op), cur_pos};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.pos_v <= POS_DISTURB;
      s_reg.op <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs from state flops; position and its flags decoded through the override mux
  always_comb begin
    rdata = s_reg.rdata;
    trip_cmd = s_reg.trip;
    close_cmd = s_reg.close_o;
    open_cmd = s_reg.open_o;
    command_success_flag = s_reg.succ;
    command_fail_flag = s_reg.fail;
    pos_overridden = s_reg.manpos[2];
    position = cur_pos;
    pos_open = cur_pos == POS_OPEN;
    pos_closed = cur_pos == POS_CLOSED;
    pos_indet = cur_pos == POS_INDET;
    pos_disturb = cur_pos == POS_DISTURB;
    bypass_active = s_reg.byp_on;
  end
endmodule
`default_nettype wire

// File: verif/scs_checker.sv
// port assertions for the switchgear command supervisor
`timescale 1ns/1ps
`default_nettype none
module scs_checker
  import scs_pkg::*;
#(
  parameter int SLOTS = SLOT_N
) (
  input wire logic clock, // device clock
  input wire logic rst, // async reset
  input wire logic [ILK_N-1:0] ilk_close, // close interlocks
  input wire logic [ILK_N-1:0] ilk_open, // open interlocks
  input wire logic [SLOTS-1:0] prot_trip, // trip sources
  input wire logic trip_block, // trip suppress
  input wire logic auto_reclose_unit, // reclose request
  input wire logic trip_cmd, // trip coil
  input wire logic close_cmd, // close coil
  input wire logic open_cmd, // open coil
  input wire logic [1:0] position, // position code
  input wire logic pos_open, // open flag
  input wire logic pos_indet, // intermediate flag
  input wire logic pos_disturb, // disturbed flag
  input wire logic command_success_flag, // success
  input wire logic command_fail_flag, // failure
  input wire logic bypass_active // bypass on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // coil pulses, flags and causes
  AST_CLOSE_ONE_PULSE: assert property ($rose(close_cmd) |-> close_cmd[*4] ##1 !close_cmd)
    else $error("close pulse length wrong");
  AST_OPEN_PULSE: assert property ($rose(open_cmd) |-> open_cmd[*4] ##1 !open_cmd)
    else $error("open pulse length wrong");
  AST_NO_BOTH: assert property (!(open_cmd && close_cmd))
    else $error("open and close driven together");
  AST_OPEN_CODE: assert property (pos_open == (position == POS_OPEN))
    else $error("open flag disagrees with code");
  AST_DISTURB_CODE: assert property (pos_disturb == (position == POS_DISTURB))
    else $error("disturbed flag disagrees with code");
  AST_TRIP_CAUSE: assert property ($rose(trip_cmd) |-> $past(|prot_trip) && !$past(trip_block))
    else $error("trip without an active source");
  AST_CLOSE_ILK: assert property ($rose(close_cmd) |->
    ($past(ilk_close) == 3'h0) || $past(auto_reclose_unit) || $past(bypass_active))
    else $error("close issued against interlock");
  AST_OPEN_ILK: assert property ($rose(open_cmd) |->
    ($past(ilk_open) == 3'h0) || $past(bypass_active))
    else $error("open issued against interlock");
  AST_FAIL_DISTURB: assert property ($rose(command_fail_flag) |-> pos_disturb && !pos_indet)
    else $error("failure without disturbed position");
  AST_SUCCESS_SETTLED: assert property ($rose(command_success_flag) |-> !pos_indet)
    else $error("success while intermediate");
  C_TRIP: cover property ($rose(trip_cmd));
  C_FAIL: cover property ($rose(command_fail_flag));
  C_BYPASS: cover property ($rose(bypass_active));
endmodule
bind scs_supervisor scs_checker #(.SLOTS(SLOTS)) u_chk (.clock(clock), .rst(rst),
  .ilk_close(ilk_close), .ilk_open(ilk_open), .prot_trip(prot_trip), .trip_block(trip_block),
  .auto_reclose_unit(auto_reclose_unit), .trip_cmd(trip_cmd), .close_cmd(close_cmd),
  .open_cmd(open_cmd), .position(position), .pos_open(pos_open), .pos_indet(pos_indet),
  .pos_disturb(pos_disturb), .command_success_flag(command_success_flag),
  .command_fail_flag(command_fail_flag), .bypass_active(bypass_active));
`default_nettype wire

// File: verif/scs_breaker.sv
// behavioural breaker: coils in, open auxiliary contact out
`timescale 1ns/1ps
`default_nettype none
module scs_breaker #(
  parameter int DLY = 5
) (
  input wire logic clock, // device clock
  input wire logic rst, // async reset
  input wire logic open_cmd, // open coil
  input wire logic close_cmd, // close coil
  input wire logic trip_cmd, // trip coil
  input wire logic stuck, // mechanism jammed
  output logic aux_open // high while open
);
  int cnt;
  logic tgt;
  // mechanism moves DLY+1 cycles after the coil drops, not while jammed
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      aux_open <= 1'b1;
      tgt <= 1'b1;
      cnt <= 0;
    end else if (open_cmd || trip_cmd) begin
      tgt <= 1'b1;
      cnt <= 0;
    end else if (close_cmd) begin
      tgt <= 1'b0;
      cnt <= 0;
    end else if (aux_open != tgt && !stuck) begin
      cnt <= cnt + 1;
      if (cnt >= DLY) begin
        aux_open <= tgt;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/scs_supervisor_bench.sv
// self-checking bench for the switchgear command supervisor
`timescale 1ns/1ps
`default_nettype none
module scs_supervisor_bench
  import scs_pkg::*;
;
  localparam int TRAV = 20;
  localparam int DWL = 10;
  localparam int HOLD = 6;
  localparam int BYP = 15;
  logic clock, rst, wr, rd, aux_open_in, trip_block, trip_release_signal, auto_reclose_unit;
  logic external_close_request, external_open_request, bypass_duration, stuck;
  logic trip_cmd, close_cmd, open_cmd, pos_open, pos_closed, pos_indet, pos_disturb;
  logic command_success_flag, command_fail_flag, pos_overridden, bypass_active, sc, so;
  logic [7:0] addr;
  logic [7:0] prot_trip;
  logic [31:0] wdata, rdata, rv;
  logic [2:0] ilk_close, ilk_open;
  logic [1:0] position, code;
  int num_errors, n_checks, seed, k;
  scs_supervisor dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .aux_open_in(aux_open_in), .ilk_close(ilk_close), .ilk_open(ilk_open),
    .prot_trip(prot_trip), .trip_block(trip_block), .trip_release_signal(trip_release_signal),
    .auto_reclose_unit(auto_reclose_unit), .external_close_request(external_close_request),
    .external_open_request(external_open_request), .bypass_duration(bypass_duration),
    .trip_cmd(trip_cmd), .close_cmd(close_cmd), .open_cmd(open_cmd), .position(position),
    .pos_open(pos_open), .pos_closed(pos_closed), .pos_indet(pos_indet),
    .pos_disturb(pos_disturb), .command_success_flag(command_success_flag),
    .command_fail_flag(command_fail_flag), .pos_overridden(pos_overridden),
    .bypass_active(bypass_active));
  scs_breaker u_brk (.clock(clock), .rst(rst), .open_cmd(open_cmd), .close_cmd(close_cmd),
    .trip_cmd(trip_cmd), .stuck(stuck), .aux_open(aux_open_in));
  // clock generation
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // watch up to 12 cycles for a coil pulse to begin
  task automatic watch();
    sc = 1'b0;
    so = 1'b0;
    for (int i = 0; i < 12 && !sc && !so; i++) begin
      tick(1);
      sc = (close_cmd === 1'b1);
      so = (open_cmd === 1'b1);
    end
  endtask
  task automatic cmd(input int b);
    wr_reg(ADDR_CMD, 32'h1 << b);
    watch();
  endtask
  task automatic wait_pos(input logic [1:0] p, input int n);
    int i;
    i = 0;
    while (position !== p && i < n) begin
      tick(1);
      i++;
    end
    if (position !== p) begin
      num_errors++;
      conclude();
    end
  endtask
  // main sequence, expectations from a simple position model
  initial begin
    seed = 32'h5474c891;
    num_errors = 0;
    n_checks = 0;
    {rst, wr, rd, trip_block, trip_release_signal, auto_reclose_unit, stuck} = 7'h40;
    {external_close_request, external_open_request, bypass_duration} = 3'h0;
    {addr, wdata, prot_trip, ilk_close, ilk_open} = 54'h0;
    tick(4);
    chk(position, POS_DISTURB);
    rst <= 1'b0;
    rd_reg(ADDR_CTRL, rv);
    chk(rv, CTRL_RESET);
    rd_reg(8'hF0, rv);
    chk(rv, 32'h0);
    wr_reg(ADDR_CTRL, 32'h0523);
    wr_reg(ADDR_TRAVEL, TRAV);
    wr_reg(ADDR_HOLD, HOLD);
    wr_reg(ADDR_BYPASS, BYP);
    wait_pos(POS_OPEN, 20);
    cmd(CMD_PANEL_OPEN);
    chk({sc, so}, 2'b00);
    cmd(CMD_PANEL_CLOSE);
    chk({sc, so}, 2'b10);
    wait_pos(POS_CLOSED, 60);
    chk({pos_closed, pos_open}, 2'b10);
    cmd(CMD_PANEL_OPEN);
    chk(pos_indet, 1'b1);
    wait_pos(POS_OPEN, TRAV);
    chk({command_success_flag, pos_indet}, 2'b10);
    rd_reg(ADDR_STATUS, rv);
    chk(rv[5], 1'b1);
    cmd(CMD_PANEL_CLOSE);
    wait_pos(POS_CLOSED, 60);
    stuck <= 1'b1;
    cmd(CMD_PANEL_OPEN);
    tick(4);
    cmd(CMD_REM_CLOSE);
    chk({sc, so}, 2'b00);
    wait_pos(POS_DISTURB, TRAV + 10);
    chk({command_fail_flag, pos_indet}, 2'b10);
    stuck <= 1'b0;
    wait_pos(POS_OPEN, 20);
    wr_reg(ADDR_DWELL, DWL);
    cmd(CMD_PANEL_CLOSE);
    tick(27);
    chk(pos_indet, 1'b1);
    wait_pos(POS_CLOSED, 20);
    wr_reg(ADDR_DWELL, 32'h0);
    for (int i = 0; i < ILK_N; i++) begin
      ilk_open <= 3'h1 << i;
      cmd(CMD_PANEL_OPEN);
      chk({sc, so}, 2'b00);
    end
    ilk_open <= 3'h7;
    wr_reg(ADDR_CTRL, 32'h0520);
    prot_trip <= 8'h08 | (8'($random(seed)) & 8'hFA);
    tick(6);
    chk(trip_cmd, 1'b0);
    prot_trip <= 8'h04;
    tick(3);
    prot_trip <= 8'h00;
    k = 0;
    while (trip_cmd === 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    chk(k >= HOLD, 1'b1);
    chk(k < 40, 1'b1);
    wait_pos(POS_OPEN, 20);
    trip_block <= 1'b1;
    prot_trip <= 8'h01;
    tick(4);
    chk(trip_cmd, 1'b0);
    trip_block <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h0530);
    tick(4);
    chk(trip_cmd, 1'b1);
    prot_trip <= 8'h00;
    tick(3 * HOLD);
    chk(trip_cmd, 1'b1);
    trip_release_signal <= 1'b1;
    tick(HOLD + 4);
    trip_release_signal <= 1'b0;
    chk(trip_cmd, 1'b0);
    wr_reg(ADDR_CTRL, 32'h0523);
    for (int i = 0; i < ILK_N; i++) begin
      ilk_close <= 3'h1 << i;
      cmd(CMD_PANEL_CLOSE);
      chk({sc, so}, 2'b00);
    end
    ilk_close <= 3'h7;
    wr_reg(ADDR_CTRL, 32'h0520);
    auto_reclose_unit <= 1'b1;
    watch();
    auto_reclose_unit <= 1'b0;
    chk({sc, so}, 2'b10);
    wait_pos(POS_CLOSED, 60);
    {ilk_open, ilk_close} <= 6'h0;
    wr_reg(ADDR_CTRL, 32'h0522);
    {external_close_request, external_open_request} <= 2'b11;
    watch();
    chk({sc, so}, 2'b01);
    wait_pos(POS_OPEN, 40);
    {external_close_request, external_open_request} <= 2'b00;
    tick(4);
    external_close_request <= 1'b1;
    watch();
    chk({sc, so}, 2'b10);
    wait_pos(POS_CLOSED, 60);
    external_close_request <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      for (int s = 0; s < 2; s++) begin
        wr_reg(ADDR_CTRL, 32'h0520 | a);
        cmd(s == 0 ? CMD_PANEL_OPEN : CMD_REM_OPEN);
        chk(so, s == 0 ? a[0] : a[1]);
        if (so) begin
          wait_pos(POS_OPEN, 40);
          wr_reg(ADDR_CTRL, 32'h0523);
          cmd(CMD_PANEL_CLOSE);
          wait_pos(POS_CLOSED, 60);
        end
      end
    end
    ilk_open <= 3'h7;
    wr_reg(ADDR_CTRL, 32'h052B);
    wr_reg(ADDR_CMD, 32'h1 << CMD_BYP_ARM);
    cmd(CMD_PANEL_OPEN);
    chk({so, bypass_active}, 2'b11);
    wait_pos(POS_OPEN, 40);
    wr_reg(ADDR_CTRL, 32'h052F);
    tick(BYP + 5);
    chk(bypass_active, 1'b0);
    bypass_duration <= 1'b1;
    tick(3);
    bypass_duration <= 1'b0;
    chk(bypass_active, 1'b1);
    tick(BYP + 5);
    chk(bypass_active, 1'b0);
    code = 2'($random(seed));
    wr_reg(ADDR_MANPOS, 32'h4 | code);
    tick(2);
    chk({pos_overridden, position}, {1'b1, code});
    wr_reg(ADDR_MANPOS, 32'h0);
    wr_reg(ADDR_CTRL, 32'h0503);
    tick(3);
    chk({pos_overridden, position}, {1'b0, POS_DISTURB});
    prot_trip <= 8'h01;
    bypass_duration <= 1'b1;
    tick(2);
    chk({trip_cmd, bypass_active}, 2'b11);
    rst <= 1'b1;
    bypass_duration <= 1'b0;
    tick(2);
    chk({trip_cmd, bypass_active, position}, {2'b00, POS_DISTURB});
    rst <= 1'b0;
    tick(2);
    conclude();
  end
endmodule
`default_nettype wire
